/* design/dsp_decode_defines.vh */
/*
 Constants for the DSP instruction decoder: opcode patterns, field positions,
 register indices and reset values. Included by the decoder files only.
*/
`ifndef DSP_DECODE_DEFINES_VH
`define DSP_DECODE_DEFINES_VH

// Opcode class patterns on the first fetched half.
`define DD_TOP_MSB        15
`define DD_TOP_LSB        10
`define DD_TOP_CODE       6'h3c
`define SD_TOP_CODE       6'h3d
`define OP32_TOP_MSB      15
`define OP32_TOP_LSB      11
`define OP32_TOP_CODE     5'h1f
`define GRP_MSB           15
`define GRP_LSB           8
`define GRP_EXT_LOOP      8'h8c
`define GRP_LEGACY_LOOP   8'h8d
`define GRP_HEAD_LOAD     8'h8e
`define GRP_TAIL_LOAD     8'h8f
`define GRP_MOD_LOAD      8'h4e
`define GRP_SYSREG        8'h4f

// Field positions.
`define FIELD_A_MSB       9
`define FIELD_X_MSB       9
`define FIELD_X_LSB       5
`define FIELD_Y_MSB       4
`define FIELD_Y_LSB       0
`define ALU_MSB           15
`define ALU_LSB           8
`define MUL_MSB           7
`define MUL_LSB           0
`define IMM_MSB           7
`define SYSREG_DIR_BIT    7
`define SYSREG_IDX_MSB    3
`define MOD_SEL_BIT       0

// System register indices of the DSP unit.
`define SREG_XY_PTR       4'h0
`define SREG_MOD_START    4'h1
`define SREG_MOD_END      4'h2
`define SREG_LOOP_HEAD    4'h3
`define SREG_LOOP_TAIL    4'h4
`define SREG_LOOP_FLAGS   4'h5

// Reset values and steps.
`define RESET_PC          32'ha000_0000
`define HALF_STEP         32'h0000_0002
`define XY_STEP           16'h0002
`define XY_PTR_RESET      16'h0000
`define MOD_RESET         16'h0000

// Loop state flag encodings.
`define LOOP_NONE         2'h0
`define LOOP_ONE          2'h1
`define LOOP_TWO          2'h2
`define LOOP_MANY         2'h3

`endif

/* design/loop_state_unit.v */
/*
 Repeat loop state: loop state flags, loop head and tail pointers and count.
 Assumes the decoder presents one load pulse at a time with its operands.
*/
`timescale 1ns/1ps
`include "dsp_decode_defines.vh"

module loop_state_unit #(
   parameter CW = 8
) (
   input  wire          mclk_i,
   input  wire          rst_n_i,
   input  wire          ext_load_i,
   input  wire          legacy_load_i,
   input  wire          head_load_i,
   input  wire          tail_load_i,
   input  wire [CW-1:0] count_i,
   input  wire [31:0]   target_i,
   input  wire [31:0]   next_pc_i,
   output reg  [1:0]    flags_o,
   output reg  [31:0]   head_o,
   output reg  [31:0]   tail_o,
   output reg  [CW-1:0] count_o
);

   reg [1:0] next_flags;

   // Flags follow the loaded count.
   always @* begin
      if (count_i == {CW{1'b0}}) begin
         next_flags = `LOOP_NONE;
      end else if (count_i == {{(CW-1){1'b0}}, 1'b1}) begin
         next_flags = `LOOP_ONE;
      end else if (count_i == {{(CW-2){1'b0}}, 2'h2}) begin
         next_flags = `LOOP_TWO;
      end else begin
         next_flags = `LOOP_MANY;
      end
   end

   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         flags_o <= `LOOP_NONE;
         head_o  <= 32'h0000_0000;
         tail_o  <= 32'h0000_0000;
         count_o <= {CW{1'b0}};
      end else begin
         if (ext_load_i || legacy_load_i) begin
            flags_o <= next_flags;
            count_o <= count_i;
         end
         // The legacy load runs through the extended load path and loops the next instruction.
         if (legacy_load_i) begin
            head_o <= next_pc_i;
            tail_o <= next_pc_i;
         end else begin
            if (head_load_i) begin
               head_o <= target_i;
            end
            if (tail_load_i) begin
               tail_o <= target_i;
            end
         end
      end
   end

endmodule // loop_state_unit

/* design/dsp_instruction_decode.v */
/*
 DSP extension instruction decoder: fetches 16-bit halves, classifies them,
 pairs 32-bit operation codes and drives the DSP datapath and X/Y memory.
 Assumes the fetch path answers a held request with one valid half per cycle.
*/
`timescale 1ns/1ps
`include "dsp_decode_defines.vh"

module dsp_instruction_decode #(
   parameter CW = 8
) (
   input  wire          mclk_i,
   input  wire          rst_n_i,
   input  wire          dsp_enable_i,
   input  wire          redirect_i,
   input  wire [31:0]   redirect_addr_i,
   input  wire [31:0]   cpu_operand_i,
   output wire          fetch_req_o,
   output reg  [31:0]   fetch_addr_o,
   input  wire          fetch_valid_i,
   input  wire [15:0]   fetch_data_i,
   output reg           cpu_instr_valid_o,
   output reg  [15:0]   cpu_instr_o,
   output reg           illegal_o,
   output reg           xy_xfer_o,
   output reg  [9:0]    xy_field_o,
   output reg  [15:0]   xy_addr_o,
   output reg           sd_xfer_o,
   output reg  [9:0]    sd_field_o,
   output reg           alu_valid_o,
   output reg  [7:0]    alu_code_o,
   output reg           mul_valid_o,
   output reg  [7:0]    mul_code_o,
   output reg  [2:0]    par_count_o,
   output reg           sysreg_wr_o,
   output reg           sysreg_rd_o,
   output reg  [3:0]    sysreg_idx_o,
   output reg  [31:0]   sysreg_rdata_o,
   output wire [1:0]    loop_state_flags_o,
   output wire [31:0]   loop_head_pointer_o,
   output wire [31:0]   loop_tail_pointer_o,
   output wire [CW-1:0] loop_count_o
);

   localparam ST_FIRST  = 1'b0;
   localparam ST_SECOND = 1'b1;

   reg          state;
   reg  [15:0]  first_half;
   reg  [15:0]  xy_ptr;
   reg  [15:0]  mod_start;
   reg  [15:0]  mod_end;
   reg          ext_load;
   reg          legacy_load;
   reg          head_load;
   reg          tail_load;
   reg  [CW-1:0] load_count;
   reg  [31:0]  load_target;
   reg  [31:0]  load_next_pc;

   wire         take;
   wire [15:0]  ins;
   wire [7:0]   grp;
   wire         is_dd;
   wire         is_sd;
   wire         is_op32;
   wire         is_dsp_only;
   wire [9:0]   field_a;
   wire         x_act;
   wire         y_act;
   wire [15:0]  xy_next;
   wire [2:0]   xfer_cnt;
   wire [31:0]  next_pc;

   assign fetch_req_o = 1'b1;
   assign take        = fetch_valid_i && !redirect_i;
   assign ins         = (state == ST_SECOND) ? first_half : fetch_data_i;
   assign grp         = ins[`GRP_MSB:`GRP_LSB];
   assign is_dd       = ins[`DD_TOP_MSB:`DD_TOP_LSB] == `DD_TOP_CODE;
   assign is_sd       = ins[`DD_TOP_MSB:`DD_TOP_LSB] == `SD_TOP_CODE;
   assign is_op32     = ins[`OP32_TOP_MSB:`OP32_TOP_LSB] == `OP32_TOP_CODE;
   assign is_dsp_only = is_dd || is_sd || is_op32 || (grp == `GRP_EXT_LOOP) ||
                        (grp == `GRP_LEGACY_LOOP) || (grp == `GRP_HEAD_LOAD) ||
                        (grp == `GRP_TAIL_LOAD) || (grp == `GRP_MOD_LOAD) ||
                        (grp == `GRP_SYSREG);
   assign field_a     = ins[`FIELD_A_MSB:0];
   assign x_act       = field_a[`FIELD_X_MSB:`FIELD_X_LSB] != 5'h00;
   assign y_act       = field_a[`FIELD_Y_MSB:`FIELD_Y_LSB] != 5'h00;
   assign xfer_cnt    = {2'b00, x_act} + {2'b00, y_act};
   assign next_pc     = fetch_addr_o + `HALF_STEP;
   // Post-increment wraps from the buffer end back to its start.
   assign xy_next     = ((mod_start != mod_end) && (xy_ptr == mod_end)) ?
                        mod_start : xy_ptr + `XY_STEP;

   // Fetch sequencing: a 32-bit code is the half at 2n then the half at 2n + 2.
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state        <= ST_FIRST;
         first_half   <= 16'h0000;
         fetch_addr_o <= `RESET_PC;
      end else if (redirect_i) begin
         state        <= ST_FIRST;
         fetch_addr_o <= redirect_addr_i;
      end else if (take) begin
         fetch_addr_o <= next_pc;
         case (state)
            ST_FIRST: begin
               // A long first half pairs only while the extension is enabled.
               first_half <= fetch_data_i;
               if (is_op32 && dsp_enable_i) begin
                  state <= ST_SECOND;
               end
            end
            ST_SECOND: begin
               state <= ST_FIRST;
            end
            default: begin
               state <= ST_FIRST;
            end
         endcase
      end
   end

   // Issue stage: one registered pulse set per completed instruction.
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cpu_instr_valid_o <= 1'b0;
         cpu_instr_o       <= 16'h0000;
         illegal_o         <= 1'b0;
         xy_xfer_o         <= 1'b0;
         xy_field_o        <= 10'h000;
         xy_addr_o         <= `XY_PTR_RESET;
         sd_xfer_o         <= 1'b0;
         sd_field_o        <= 10'h000;
         alu_valid_o       <= 1'b0;
         alu_code_o        <= 8'h00;
         mul_valid_o       <= 1'b0;
         mul_code_o        <= 8'h00;
         par_count_o       <= 3'h0;
         sysreg_wr_o       <= 1'b0;
         sysreg_rd_o       <= 1'b0;
         sysreg_idx_o      <= 4'h0;
         sysreg_rdata_o    <= 32'h0000_0000;
         xy_ptr            <= `XY_PTR_RESET;
         mod_start         <= `MOD_RESET;
         mod_end           <= `MOD_RESET;
         ext_load          <= 1'b0;
         legacy_load       <= 1'b0;
         head_load         <= 1'b0;
         tail_load         <= 1'b0;
         load_count        <= {CW{1'b0}};
         load_target       <= 32'h0000_0000;
         load_next_pc      <= 32'h0000_0000;
      end else begin
         cpu_instr_valid_o <= 1'b0;
         illegal_o         <= 1'b0;
         xy_xfer_o         <= 1'b0;
         sd_xfer_o         <= 1'b0;
         alu_valid_o       <= 1'b0;
         mul_valid_o       <= 1'b0;
         sysreg_wr_o       <= 1'b0;
         sysreg_rd_o       <= 1'b0;
         ext_load          <= 1'b0;
         legacy_load       <= 1'b0;
         head_load         <= 1'b0;
         tail_load         <= 1'b0;
         if (take && (state == ST_SECOND)) begin
            // Field A transfers and field B arithmetic issue together.
            alu_code_o  <= fetch_data_i[`ALU_MSB:`ALU_LSB];
            mul_code_o  <= fetch_data_i[`MUL_MSB:`MUL_LSB];
            alu_valid_o <= fetch_data_i[`ALU_MSB:`ALU_LSB] != 8'h00;
            mul_valid_o <= fetch_data_i[`MUL_MSB:`MUL_LSB] != 8'h00;
            par_count_o <= xfer_cnt + {2'b00, fetch_data_i[`ALU_MSB:`ALU_LSB] != 8'h00}
                           + {2'b00, fetch_data_i[`MUL_MSB:`MUL_LSB] != 8'h00};
            xy_field_o  <= field_a;
            if (x_act || y_act) begin
               xy_xfer_o <= 1'b1;
               xy_addr_o <= xy_ptr;
               xy_ptr    <= xy_next;
            end
         end else if (take && (state == ST_FIRST)) begin
            if (is_dsp_only && !dsp_enable_i) begin
               illegal_o <= 1'b1;
            end else if (is_op32) begin
               par_count_o <= 3'h0;
            end else if (is_dd) begin
               xy_xfer_o   <= 1'b1;
               xy_field_o  <= field_a;
               xy_addr_o   <= xy_ptr;
               xy_ptr      <= xy_next;
               par_count_o <= xfer_cnt;
            end else if (is_sd) begin
               sd_xfer_o   <= 1'b1;
               sd_field_o  <= field_a;
               par_count_o <= 3'h1;
            end else if (grp == `GRP_EXT_LOOP) begin
               ext_load   <= 1'b1;
               load_count <= ins[CW-1:0];
            end else if (grp == `GRP_LEGACY_LOOP) begin
               legacy_load  <= 1'b1;
               load_count   <= ins[CW-1:0];
               load_next_pc <= next_pc;
            end else if (grp == `GRP_HEAD_LOAD) begin
               head_load   <= 1'b1;
               load_target <= next_pc + {{23{ins[`IMM_MSB]}}, ins[`IMM_MSB:0], 1'b0};
            end else if (grp == `GRP_TAIL_LOAD) begin
               tail_load   <= 1'b1;
               load_target <= next_pc + {{23{ins[`IMM_MSB]}}, ins[`IMM_MSB:0], 1'b0};
            end else if (grp == `GRP_MOD_LOAD) begin
               if (ins[`MOD_SEL_BIT]) begin
                  mod_end <= cpu_operand_i[15:0];
               end else begin
                  mod_start <= cpu_operand_i[15:0];
               end
            end else if (grp == `GRP_SYSREG) begin
               // Only the pointer and the modulo bounds take writes; others just strobe.
               sysreg_idx_o <= ins[`SYSREG_IDX_MSB:0];
               if (ins[`SYSREG_DIR_BIT]) begin
                  sysreg_wr_o <= 1'b1;
                  case (ins[`SYSREG_IDX_MSB:0])
                     `SREG_XY_PTR: begin
                        xy_ptr <= cpu_operand_i[15:0];
                     end
                     `SREG_MOD_START: begin
                        mod_start <= cpu_operand_i[15:0];
                     end
                     `SREG_MOD_END: begin
                        mod_end <= cpu_operand_i[15:0];
                     end
                     default: begin
                        sysreg_wr_o <= 1'b1;
                     end
                  endcase
               end else begin
                  sysreg_rd_o <= 1'b1;
                  case (ins[`SYSREG_IDX_MSB:0])
                     `SREG_XY_PTR: begin
                        sysreg_rdata_o <= {16'h0000, xy_ptr};
                     end
                     `SREG_MOD_START: begin
                        sysreg_rdata_o <= {16'h0000, mod_start};
                     end
                     `SREG_MOD_END: begin
                        sysreg_rdata_o <= {16'h0000, mod_end};
                     end
                     `SREG_LOOP_HEAD: begin
                        sysreg_rdata_o <= loop_head_pointer_o;
                     end
                     `SREG_LOOP_TAIL: begin
                        sysreg_rdata_o <= loop_tail_pointer_o;
                     end
                     `SREG_LOOP_FLAGS: begin
                        sysreg_rdata_o <= {30'h0000_0000, loop_state_flags_o};
                     end
                     default: begin
                        sysreg_rdata_o <= 32'h0000_0000;
                     end
                  endcase
               end
            end else begin
               cpu_instr_valid_o <= 1'b1;
               cpu_instr_o       <= fetch_data_i;
            end
         end
      end
   end

   // Both loop load forms share one state path inside the loop unit.
   loop_state_unit #(
      .CW (CW)
   ) u_loop (
      .mclk_i        (mclk_i),
      .rst_n_i       (rst_n_i),
      .ext_load_i    (ext_load),
      .legacy_load_i (legacy_load),
      .head_load_i   (head_load),
      .tail_load_i   (tail_load),
      .count_i       (load_count),
      .target_i      (load_target),
      .next_pc_i     (load_next_pc),
      .flags_o       (loop_state_flags_o),
      .head_o        (loop_head_pointer_o),
      .tail_o        (loop_tail_pointer_o),
      .count_o       (loop_count_o)
   );

endmodule // dsp_instruction_decode

/* bench/fetch_partner.sv */
/*
 Fetch-path model: a small instruction store read by half-word address.
 Assumes the bench loads the store and gates delivery through en_i.
*/
`timescale 1ns/1ps
module fetch_partner (
   input  logic        mclk_i,
   input  logic        en_i,
   input  logic [31:0] addr_i,
   output logic        valid_o,
   output logic [15:0] data_o
);
   logic [15:0] mem [0:63];
   logic [15:0] last = 16'h0000;
   // Halves of a long code sit at 2n then 2n+2, in consecutive half-word entries.
   assign valid_o = en_i;
   assign data_o  = en_i ? mem[addr_i[6:1]] : ~last;
   always @(posedge mclk_i) begin
      if (en_i) begin
         last <= data_o;
      end
   end
endmodule // fetch_partner

/* bench/dsp_decode_chk.sv */
/*
 Checker for the decoder's port behaviour.
 Assumes it is bound to the decoder top with its default encodings.
*/
`timescale 1ns/1ps
module dsp_decode_chk #(
   parameter CW = 8
) (
   input logic        mclk_i,
   input logic        rst_n_i,
   input logic        dsp_enable_i,
   input logic        redirect_i,
   input logic [31:0] fetch_addr_o,
   input logic        fetch_valid_i,
   input logic [15:0] fetch_data_i,
   input logic        cpu_instr_valid_o,
   input logic [15:0] cpu_instr_o,
   input logic        illegal_o,
   input logic        xy_xfer_o,
   input logic [9:0]  xy_field_o,
   input logic        sd_xfer_o,
   input logic [9:0]  sd_field_o,
   input logic        alu_valid_o,
   input logic [7:0]  alu_code_o,
   input logic        mul_valid_o,
   input logic [7:0]  mul_code_o,
   input logic [2:0]  par_count_o,
   input logic [31:0] loop_head_pointer_o,
   input logic [31:0] loop_tail_pointer_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   wire [7:0] hi = fetch_data_i[15:8];
   wire [7:0] lo = fetch_data_i[7:0];
   wire [9:0] f10 = fetch_data_i[9:0];
   wire take = fetch_valid_i & ~redirect_i;
   wire is32 = fetch_data_i[15:11] == 5'h1f;
   wire is_dd = fetch_data_i[15:10] == 6'h3c;
   wire is_sd = fetch_data_i[15:10] == 6'h3d;
   wire grp = hi[7:2] == 6'h23 || hi == 8'h4e || hi == 8'h4f;
   wire dsp_only = is32 | is_dd | is_sd | grp;
   logic second;
   wire first = take & ~second;
   // Marks that the next take is the second half of a long code.
   always @(posedge mclk_i) begin
      if (!rst_n_i || redirect_i) begin
         second <= 1'b0;
      end else if (fetch_valid_i) begin
         second <= !second && is32 && dsp_enable_i;
      end
   end
   addr_step_a: assert property (take |=> fetch_addr_o == $past(fetch_addr_o) + 32'h2)
      else $error("fetch address did not step by two");
   xy_issue_a: assert property (first && dsp_enable_i && is_dd |=>
      xy_xfer_o && xy_field_o == $past(f10)) else $error("double transfer not issued");
   sd_issue_a: assert property (first && dsp_enable_i && is_sd |=>
      sd_xfer_o && sd_field_o == $past(f10)) else $error("single transfer not issued");
   illegal_only_a: assert property (first && !dsp_enable_i && dsp_only |=>
      illegal_o && !xy_xfer_o && !sd_xfer_o && !cpu_instr_valid_o)
      else $error("disabled code not refused");
   no_early_a: assert property (first && dsp_enable_i && is32 |=>
      !alu_valid_o && !mul_valid_o && !cpu_instr_valid_o) else $error("long code issued early");
   op_pair_a: assert property (take && second |=>
      alu_valid_o == ($past(hi) != 8'h00) && mul_valid_o == ($past(lo) != 8'h00)
      && (!mul_valid_o || mul_code_o == $past(lo)) && alu_code_o == $past(hi))
      else $error("field B mismatch");
   par_max_a: assert property (par_count_o <= 3'd4 &&
      par_count_o >= {2'b00, alu_valid_o} + {2'b00, mul_valid_o}) else $error("bad op count");
   legacy_loop_a: assert property (first && dsp_enable_i && hi == 8'h8d |-> ##3
      loop_head_pointer_o == $past(fetch_addr_o, 3) + 32'h2
      && loop_tail_pointer_o == loop_head_pointer_o) else $error("legacy loop state wrong");
   cpu_pass_a: assert property (first && !dsp_only |=>
      cpu_instr_valid_o && cpu_instr_o == $past(fetch_data_i)) else $error("CPU code lost");
   cover property (take && second);
   cover property (illegal_o);
   cover property (first && hi == 8'h8d);
endmodule // dsp_decode_chk

bind dsp_instruction_decode dsp_decode_chk #(.CW(CW)) chk_i (.mclk_i, .rst_n_i, .dsp_enable_i,
   .redirect_i, .fetch_addr_o, .fetch_valid_i, .fetch_data_i, .cpu_instr_valid_o, .cpu_instr_o,
   .illegal_o, .xy_xfer_o, .xy_field_o, .sd_xfer_o, .sd_field_o, .alu_valid_o, .alu_code_o,
   .mul_valid_o, .mul_code_o, .par_count_o, .loop_head_pointer_o, .loop_tail_pointer_o);

/* bench/testbench.sv */
/*
 Self-checking bench for the DSP decoder with a fetch-path model.
 Assumes the decoder answers one cycle after each take.
*/
`timescale 1ns/1ps
module testbench;
   localparam [31:0] BASE = 32'ha000_0100;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, dsp_enable_i = 1'b1, redirect_i = 1'b0, fetch_en = 1'b0;
   logic [31:0] redirect_addr_i = BASE, cpu_operand_i = 32'h0;
   logic fetch_req_o, fetch_valid_i, cpu_instr_valid_o, illegal_o, xy_xfer_o, sd_xfer_o;
   logic alu_valid_o, mul_valid_o, sysreg_wr_o, sysreg_rd_o;
   logic [31:0] fetch_addr_o, sysreg_rdata_o, loop_head_pointer_o, loop_tail_pointer_o;
   logic [15:0] fetch_data_i, cpu_instr_o, xy_addr_o, s_cpuw, s_xya;
   logic [9:0] xy_field_o, sd_field_o;
   logic [7:0] alu_code_o, mul_code_o, loop_count_o;
   logic [5:0] p1, p2;
   logic [3:0] sysreg_idx_o;
   logic [2:0] par_count_o;
   logic [1:0] loop_state_flags_o, s_sys;
   int fails = 0, check_count = 0;
   typedef struct {logic [15:0] c1; logic [15:0] c2; logic en; int kind;} row_t;
   row_t rows [8] = '{'{16'h0009, 16'h0009, 1'b1, 0}, '{16'hf2a3, 16'h0009, 1'b1, 1},
      '{16'hf555, 16'h0009, 1'b1, 2}, '{16'hf821, 16'h1234, 1'b1, 3},
      '{16'hf800, 16'h0034, 1'b1, 3}, '{16'hf2a3, 16'h0009, 1'b0, 4},
      '{16'hf821, 16'h1234, 1'b0, 4}, '{16'h4f05, 16'h0009, 1'b0, 4}};
   logic [15:0] mod_exp [4] = '{16'h0010, 16'h0012, 16'h0014, 16'h0010};

   dsp_instruction_decode #(.CW(8)) dsp_instruction_decode_i (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .dsp_enable_i(dsp_enable_i), .redirect_i(redirect_i),
      .redirect_addr_i(redirect_addr_i), .cpu_operand_i(cpu_operand_i),
      .fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o),
      .fetch_valid_i(fetch_valid_i), .fetch_data_i(fetch_data_i),
      .cpu_instr_valid_o(cpu_instr_valid_o), .cpu_instr_o(cpu_instr_o), .illegal_o(illegal_o),
      .xy_xfer_o(xy_xfer_o), .xy_field_o(xy_field_o), .xy_addr_o(xy_addr_o),
      .sd_xfer_o(sd_xfer_o), .sd_field_o(sd_field_o), .alu_valid_o(alu_valid_o),
      .alu_code_o(alu_code_o), .mul_valid_o(mul_valid_o), .mul_code_o(mul_code_o),
      .par_count_o(par_count_o), .sysreg_wr_o(sysreg_wr_o), .sysreg_rd_o(sysreg_rd_o),
      .sysreg_idx_o(sysreg_idx_o), .sysreg_rdata_o(sysreg_rdata_o),
      .loop_state_flags_o(loop_state_flags_o), .loop_head_pointer_o(loop_head_pointer_o),
      .loop_tail_pointer_o(loop_tail_pointer_o), .loop_count_o(loop_count_o));
   fetch_partner fetch_partner_i (.mclk_i(mclk_i), .en_i(fetch_en), .addr_i(fetch_addr_o),
      .valid_o(fetch_valid_i), .data_o(fetch_data_i));

   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Restarts fetch at BASE and lets exactly two halves be taken.
   task automatic exec(input logic [15:0] c1, input logic [15:0] c2, input logic en,
                       input logic [31:0] op);
      fetch_partner_i.mem[0] = c1;
      fetch_partner_i.mem[1] = c2;
      @(negedge mclk_i) redirect_i = 1'b1;
      @(negedge mclk_i) redirect_i = 1'b0;
      fetch_en = 1'b1;
      dsp_enable_i = en;
      cpu_operand_i = op;
      @(negedge mclk_i) p1 = {cpu_instr_valid_o, xy_xfer_o, sd_xfer_o, illegal_o, alu_valid_o,
                              mul_valid_o};
      s_cpuw = cpu_instr_o;
      s_xya = xy_addr_o;
      s_sys = {sysreg_wr_o, sysreg_rd_o};
      @(negedge mclk_i) p2 = {cpu_instr_valid_o, xy_xfer_o, sd_xfer_o, illegal_o, alu_valid_o,
                              mul_valid_o};
      fetch_en = 1'b0;
      repeat (3) @(negedge mclk_i);
   endtask

   initial begin
      for (int i = 0; i < 64; i++) fetch_partner_i.mem[i] = 16'h0009;
      repeat (3) @(negedge mclk_i);
      chk(fetch_addr_o, 32'ha000_0000);
      chk(fetch_req_o, 1'b1);
      chk(loop_state_flags_o, 32'h0);
      rst_n_i = 1'b1;
      foreach (rows[i]) begin
         exec(rows[i].c1, rows[i].c2, rows[i].en, 32'h0);
         chk(fetch_addr_o, BASE + 32'h4);
         case (rows[i].kind)
            0: begin
               chk(p1, 6'h20);
               chk(s_cpuw, rows[i].c1);
            end
            1: begin
               chk(p1, 6'h10);
               chk(xy_field_o, rows[i].c1[9:0]);
               chk(par_count_o, (rows[i].c1[9:5] != 0) +
                   (rows[i].c1[4:0] != 0));
            end
            2: begin
               chk(p1, 6'h08);
               chk(sd_field_o, rows[i].c1[9:0]);
            end
            3: begin
               chk(p1, 6'h00);
               chk(p2, {1'b0, rows[i].c1[9:0] != 0, 2'b00, rows[i].c2[15:8] != 0,
                   rows[i].c2[7:0] != 0});
               chk(mul_code_o, rows[i].c2[7:0]);
               chk(alu_code_o, rows[i].c2[15:8]);
               chk(xy_field_o, rows[i].c1[9:0]);
               chk(par_count_o, (rows[i].c1[9:5] != 0) + (rows[i].c1[4:0] != 0)
                   + (rows[i].c2[15:8] != 0) + (rows[i].c2[7:0] != 0));
            end
            default: chk(p1, 6'h04);
         endcase
      end
      exec(16'h8d03, 16'h0009, 1'b1, 32'h0);
      chk({loop_state_flags_o, loop_count_o}, {2'h3, 8'h03});
      chk(loop_head_pointer_o, BASE + 32'h2);
      chk(loop_tail_pointer_o, BASE + 32'h2);
      exec(16'h8d02, 16'h0009, 1'b0, 32'h0);
      chk(loop_count_o, 8'h03);
      exec(16'h8c01, 16'h0009, 1'b1, 32'h0);
      chk({loop_state_flags_o, loop_count_o}, {2'h1, 8'h01});
      exec(16'h8e04, 16'h0009, 1'b1, 32'h0);
      exec(16'h8ffc, 16'h0009, 1'b1, 32'h0);
      chk(loop_tail_pointer_o, BASE - 32'h6);
      exec(16'h4f83, 16'h0009, 1'b1, 32'h55);
      chk(s_sys, 32'h2);
      exec(16'h4f03, 16'h0009, 1'b1, 32'h0);
      chk(s_sys, 32'h1);
      chk(sysreg_rdata_o, BASE + 32'ha);
      chk(sysreg_idx_o, 4'h3);
      exec(16'h4f80, 16'h0009, 1'b1, 32'h10);
      exec(16'h4f81, 16'h0009, 1'b1, 32'h10);
      exec(16'h4e01, 16'h0009, 1'b1, 32'h14);
      foreach (mod_exp[i]) begin
         exec(16'hf001, 16'h0009, 1'b1, 32'h0);
         chk(s_xya, mod_exp[i]);
      end
      exec(16'h4f00, 16'h0009, 1'b1, 32'h0);
      chk(sysreg_rdata_o, 32'h12);
      exec(16'h4f05, 16'h0009, 1'b1, 32'h0);
      chk(sysreg_rdata_o, 32'h1);
      @(negedge mclk_i) rst_n_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      chk(fetch_addr_o, 32'ha000_0000);
      chk({loop_state_flags_o, loop_count_o}, 32'h0);
      chk(loop_tail_pointer_o, 32'h0);
      rst_n_i = 1'b1;
      exec(16'h4e00, 16'h0009, 1'b1, 32'h20);
      exec(16'hf001, 16'h0009, 1'b1, 32'h0);
      chk(s_xya, 16'h0000);
      exec(16'hf001, 16'h0009, 1'b1, 32'h0);
      chk(s_xya, 16'h0020);
      wrap_up();
   end

   initial begin
      #20000;
      fails++;
      wrap_up();
   end
endmodule // testbench
